/* shared/mtpc_pkg.sv */
`default_nettype none
package mtpc_pkg;
  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_RANGE      = 8'h04;
  localparam logic [7:0] OFF_RATIO      = 8'h08;
  localparam logic [7:0] OFF_OFFSET     = 8'h0c;
  localparam logic [7:0] OFF_PRESET     = 8'h10;
  localparam logic [7:0] OFF_CMD        = 8'h14;
  localparam logic [7:0] OFF_STATUS     = 8'h18;
  localparam logic [7:0] OFF_REV        = 8'h1c;
  localparam logic [7:0] OFF_LOWER      = 8'h20;
  localparam logic [7:0] OFF_UPPER      = 8'h24;
  localparam logic [7:0] OFF_STEPS      = 8'h28;
  localparam logic [7:0] OFF_POSITION   = 8'h2c;
  localparam logic [7:0] OFF_NVM_WRITES = 8'h30;

  // Control register field positions.
  localparam int CTRL_WRAP_EN    = 0;
  localparam int CTRL_ABS_PERMIT = 1;
  localparam int CTRL_MANUAL     = 2;
  // Command register field positions (write one to act).
  localparam int CMD_PRESET      = 0;
  localparam int CMD_CLEAR       = 1;
  localparam int CMD_HOME_DONE   = 2;
  localparam int CMD_HOME_START  = 3;
  // Status register field positions.
  localparam int ST_COORD        = 0;
  localparam int ST_FACTORY      = 1;
  localparam int ST_USER         = 2;
  localparam int ST_HOMING       = 3;

  // Revolution span of the sensor; the two small frames manage half.
  localparam logic [11:0] SPAN_LARGE_REV = 12'h708;  // 1800
  localparam logic [11:0] SPAN_SMALL_REV = 12'h384;  // 900
  // Default offset ratio in hundredths of a percent (50.00 %).
  localparam logic [13:0] RATIO_DEFAULT  = 14'h1388;
  localparam logic [13:0] RATIO_FULL     = 14'h2710;  // 100.00 %
  localparam logic [31:0] PRESET_DEFAULT = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_BOOT  = 2'b00,
    ST_RUN   = 2'b01,
    ST_HOME  = 2'b10
  } mode_t;
endpackage
`default_nettype wire

/* hdl/mtpc_range_calc.sv */
`default_nettype none
// Builds the coordinate range bounds from range and offset ratio.
module mtpc_range_calc #(
  parameter int W = 16
) (
  input  wire logic [W-1:0]  range_rev,   // Generation range in revolutions
  input  wire logic [13:0]   ratio,       // Offset ratio, hundredths of percent
  output logic signed [W:0]  lower,       // Lower bound, revolutions
  output logic signed [W:0]  upper        // Upper bound, revolutions
);
  logic [W+13:0] prod;
  logic [W-1:0]  below;

  always_comb begin
    prod  = (W+14)'(range_rev) * (W+14)'(ratio);
    below = W'(prod / (W+14)'(mtpc_pkg::RATIO_FULL));
    lower = -$signed({1'b0, below});
    upper = $signed({1'b0, range_rev}) - $signed({1'b0, below});
  end
endmodule // mtpc_range_calc
`default_nettype wire

/* hdl/mtpc_core.sv */
`default_nettype none
// Functional notes
// - Absolute revolutions kept to 1800, small frames 900
// - Count past limit restarts at one
// - Coordinate settings sampled only at power-up
// - Initial coordinate built on every power-up
// - Default splits span half each side
// - Lower bound is minus ratio times range
// - Wrap presets position back into range
// - Crossing wrap boundary shifts position by range times steps per rev
// - Step counter ignores wrap presets
// - Step counter rolls over, never saturates
// - Coordinate flag shows coordinate is set
// - No coordinate blocks homing, and absolute moves unless CTRL_ABS_PERMIT set
// - Factory home fixed, flag shows it
// - User home flag; clear removes it
// - User home write pulses nonvolatile store
// - Preset loads positions, sets home
module mtpc_core #(
  parameter int            REV_W       = 16,
  parameter int            STEPS_REV   = 1000,
  parameter logic [1:0]    FACTORY_HOME = 2'b00
) (
  input  wire logic        clk,            // 250 MHz clock
  input  wire logic        rst,            // Synchronous reset, high
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB direction
  input  wire logic [7:0]  paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic             pready,         // APB ready
  output logic [31:0]      prdata,         // APB read data
  output logic             pslverr,        // APB error, unmapped address
  input  wire logic        small_frame,    // Sensor manages 900 revolutions
  input  wire logic        step_pulse,     // One motor step this cycle
  input  wire logic        step_dir,       // Step direction, high is forward
  input  wire logic        factory_home,   // Sensor holds factory home
  input  wire logic        homing_req,     // Request high-speed homing
  input  wire logic        abs_move_req,   // Request absolute positioning
  output logic             homing_grant,   // Homing accepted
  output logic             abs_move_grant, // Absolute move accepted
  output logic             coordinate_established_flag, // Coordinate set
  output logic             factory_home_stored_flag,    // Factory home present
  output logic             user_home_stored_flag,       // User home present
  output logic             nvm_write       // Store home info pulse
);
  localparam int SW = REV_W + 1;

  typedef mtpc_pkg::mode_t mode_t_w;

  typedef struct packed {
    mode_t_w                 mode;
    logic [2:0]              ctrl;
    logic [REV_W-1:0]        range_cfg;
    logic [13:0]             ratio_cfg;
    logic [31:0]             offset_cfg;
    logic [31:0]             preset_cfg;
    logic [REV_W-1:0]        range_act;
    logic [13:0]             ratio_act;
    logic [31:0]             offset_act;
    logic [REV_W-1:0]        span;
    logic signed [SW-1:0]    rev;
    logic [REV_W-1:0]        sensor_rev;
    logic [31:0]             step_in_rev;
    logic signed [31:0]      steps;
    logic signed [31:0]      position;
    logic                    coord;
    logic                    user_home;
    logic                    factory;
    logic                    nvm;
    logic [31:0]             nvm_count;
    logic [31:0]             rdata;
    logic                    cfg_kept;
  } state_t;

  state_t             cur;
  state_t             next_cur;
  logic signed [SW-1:0] lower;
  logic signed [SW-1:0] upper;
  logic               wr;
  logic               rd;

  mtpc_range_calc #(.W(REV_W)) u_range (
    .range_rev (cur.range_act),
    .ratio     (cur.ratio_act),
    .lower     (lower),
    .upper     (upper)
  );

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= mtpc_pkg::OFF_NVM_WRITES) && (a[1:0] == 2'b00);
  endfunction

  assign wr      = psel && penable && pwrite && mapped(paddr);
  assign rd      = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata  = cur.rdata;

  always_comb begin
    logic [REV_W-1:0] lim;
    logic signed [31:0] width;
    next_cur = cur;
    lim      = '0;
    width    = '0;
    next_cur.nvm = 1'b0;
    next_cur.factory = factory_home;
    if (wr) begin
      case (paddr)
        mtpc_pkg::OFF_CTRL:   next_cur.ctrl = pwdata[2:0];
        mtpc_pkg::OFF_RANGE:  next_cur.range_cfg = pwdata[REV_W-1:0];
        mtpc_pkg::OFF_RATIO:  next_cur.ratio_cfg = pwdata[13:0];
        mtpc_pkg::OFF_OFFSET: next_cur.offset_cfg = pwdata;
        mtpc_pkg::OFF_PRESET: next_cur.preset_cfg = pwdata;
        default: ;
      endcase
    end
    case (cur.mode)
      mtpc_pkg::ST_BOOT: begin
        // Settings are latched once here so mid-run edits wait for a power cycle.
        next_cur.span = small_frame ? REV_W'(mtpc_pkg::SPAN_SMALL_REV)
                                    : REV_W'(mtpc_pkg::SPAN_LARGE_REV);
        if (cur.ctrl[mtpc_pkg::CTRL_MANUAL]) begin
          next_cur.range_act  = cur.range_cfg;
          next_cur.ratio_act  = cur.ratio_cfg;
          next_cur.offset_act = cur.offset_cfg;
        end else begin
          next_cur.range_act  = next_cur.span;
          next_cur.ratio_act  = mtpc_pkg::RATIO_DEFAULT;
          next_cur.offset_act = '0;
        end
        next_cur.mode = mtpc_pkg::ST_RUN;
      end
      mtpc_pkg::ST_RUN, mtpc_pkg::ST_HOME: begin
        if (step_pulse) begin
          next_cur.steps    = cur.steps + (step_dir ? 32'sd1 : -32'sd1);
          next_cur.position = cur.position + (step_dir ? 32'sd1 : -32'sd1);
          if (step_dir) begin
            if (cur.step_in_rev == 32'(STEPS_REV - 1)) begin
              next_cur.step_in_rev = '0;
              next_cur.rev = cur.rev + SW'(1);
              lim = (cur.sensor_rev == cur.span) ? '0 : cur.sensor_rev + REV_W'(1);
              if (cur.sensor_rev == cur.span) lim = REV_W'(1);
              next_cur.sensor_rev = lim;
            end else begin
              next_cur.step_in_rev = cur.step_in_rev + 32'd1;
            end
          end else begin
            if (cur.step_in_rev == '0) begin
              next_cur.step_in_rev = 32'(STEPS_REV - 1);
              next_cur.rev = cur.rev - SW'(1);
              next_cur.sensor_rev = (cur.sensor_rev == '0) ? cur.span
                                                           : cur.sensor_rev - REV_W'(1);
            end else begin
              next_cur.step_in_rev = cur.step_in_rev - 32'd1;
            end
          end
          // The position and revolution count are preset; the step counter keeps going.
          if (cur.ctrl[mtpc_pkg::CTRL_WRAP_EN]) begin
            width = 32'(cur.range_act) * 32'(STEPS_REV);
            if (next_cur.rev >= upper) begin
              next_cur.rev = lower;
              next_cur.position = next_cur.position - width;
            end else if (next_cur.rev < lower) begin
              next_cur.rev = upper - SW'(1);
              next_cur.position = next_cur.position + width;
            end
          end
        end
        if (cur.mode == mtpc_pkg::ST_HOME) next_cur.coord = 1'b0;
        if (cur.mode == mtpc_pkg::ST_RUN && homing_req && cur.coord)
          next_cur.mode = mtpc_pkg::ST_HOME;
        if (wr && paddr == mtpc_pkg::OFF_CMD) begin
          if (pwdata[mtpc_pkg::CMD_HOME_START] && cur.coord)
            next_cur.mode = mtpc_pkg::ST_HOME;
          if (pwdata[mtpc_pkg::CMD_PRESET] || pwdata[mtpc_pkg::CMD_HOME_DONE]) begin
            next_cur.position    = $signed(cur.preset_cfg) + $signed(cur.offset_act);
            next_cur.rev         = '0;
            next_cur.step_in_rev = '0;
            next_cur.coord       = 1'b1;
            next_cur.user_home   = 1'b1;
            next_cur.nvm         = 1'b1;
            next_cur.nvm_count   = cur.nvm_count + 32'd1;
            next_cur.mode        = mtpc_pkg::ST_RUN;
          end else if (pwdata[mtpc_pkg::CMD_CLEAR]) begin
            next_cur.user_home = 1'b0;
            next_cur.coord     = cur.factory;
          end
        end
        if (cur.factory) next_cur.coord = next_cur.coord || (cur.mode == mtpc_pkg::ST_RUN);
      end
      default: next_cur.mode = mtpc_pkg::ST_BOOT;
    endcase
    if (rd) begin
      case (paddr)
        mtpc_pkg::OFF_CTRL:       next_cur.rdata = 32'(cur.ctrl);
        mtpc_pkg::OFF_RANGE:      next_cur.rdata = 32'(cur.range_cfg);
        mtpc_pkg::OFF_RATIO:      next_cur.rdata = 32'(cur.ratio_cfg);
        mtpc_pkg::OFF_OFFSET:     next_cur.rdata = cur.offset_cfg;
        mtpc_pkg::OFF_PRESET:     next_cur.rdata = cur.preset_cfg;
        mtpc_pkg::OFF_STATUS:     next_cur.rdata = {28'h0000000,
                                    cur.mode == mtpc_pkg::ST_HOME, cur.user_home,
                                    cur.factory, cur.coord};
        mtpc_pkg::OFF_REV:        next_cur.rdata = 32'(cur.rev);
        mtpc_pkg::OFF_LOWER:      next_cur.rdata = 32'(lower);
        mtpc_pkg::OFF_UPPER:      next_cur.rdata = 32'(upper);
        mtpc_pkg::OFF_STEPS:      next_cur.rdata = cur.steps;
        mtpc_pkg::OFF_POSITION:   next_cur.rdata = cur.position;
        mtpc_pkg::OFF_NVM_WRITES: next_cur.rdata = cur.nvm_count;
        default:                  next_cur.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur          <= '0;
      cur.cfg_kept <= 1'b1;
      // Settings stand for non-volatile parameters, so a power cycle keeps them.
      if (cur.cfg_kept) begin
        cur.ctrl       <= cur.ctrl;
        cur.range_cfg  <= cur.range_cfg;
        cur.ratio_cfg  <= cur.ratio_cfg;
        cur.offset_cfg <= cur.offset_cfg;
        cur.preset_cfg <= cur.preset_cfg;
      end else begin
        cur.range_cfg  <= REV_W'(mtpc_pkg::SPAN_LARGE_REV);
        cur.ratio_cfg  <= mtpc_pkg::RATIO_DEFAULT;
        cur.preset_cfg <= mtpc_pkg::PRESET_DEFAULT;
      end
    end else begin
      cur <= next_cur;
    end
  end

  assign coordinate_established_flag = cur.coord;
  assign factory_home_stored_flag    = cur.factory;
  assign user_home_stored_flag       = cur.user_home;
  assign nvm_write                   = cur.nvm;
  assign homing_grant   = homing_req && cur.coord && cur.mode == mtpc_pkg::ST_RUN;
  assign abs_move_grant = abs_move_req && cur.mode == mtpc_pkg::ST_RUN &&
                          (cur.coord || cur.ctrl[mtpc_pkg::CTRL_ABS_PERMIT]);
endmodule // mtpc_core
`default_nettype wire

/* verif/shaft_sensor_model.sv */
`default_nettype none
// Shaft sensor stand-in: turns a burst request into step pulses, fast or spaced out.
module shaft_sensor_model (
  input  wire logic        clk,         // Bench clock
  input  wire logic        go,          // Start a burst
  input  wire logic [15:0] count,       // Steps in the burst
  input  wire logic        dir,         // Burst direction, high forward
  input  wire logic        slow,        // Leave two idle cycles between steps
  output logic             step_pulse,  // One step this cycle
  output logic             step_dir,    // Direction level
  output logic             busy         // Burst still running
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] left = 16'h0000;
  logic [1:0]  gap = 2'h0;
  initial step_pulse = 1'b0;
  initial step_dir = 1'b1;
  assign busy = left != 16'h0000;
  // Each pulse stands for one step of the shaft that the sensor counts.
  always @(posedge clk) begin
    step_pulse <= 1'b0;
    if (go) begin
      left <= count;
      step_dir <= dir;
      gap <= 2'h0;
    end else if (busy && gap == 2'h0) begin
      step_pulse <= 1'b1;
      left <= left - 16'h0001;
      gap <= slow ? 2'h2 : 2'h0;
    end else if (busy) begin
      gap <= gap - 2'h1;
    end
  end
endmodule // shaft_sensor_model
`default_nettype wire

/* verif/mtpc_core_asserts.sv */
`default_nettype none
module mtpc_core_asserts (
  input wire logic clk,                          // Clock
  input wire logic rst,                          // Sync reset
  input wire logic homing_req,                   // Homing request
  input wire logic abs_move_req,                 // Absolute move request
  input wire logic homing_grant,                 // Homing accepted
  input wire logic abs_move_grant,               // Absolute move accepted
  input wire logic factory_home,                 // Sensor factory home
  input wire logic coordinate_established_flag,  // Coordinate set
  input wire logic factory_home_stored_flag,     // Factory home present
  input wire logic user_home_stored_flag,        // User home present
  input wire logic nvm_write                     // Store pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_home_needs_coord: assert property (
    homing_grant |-> homing_req && coordinate_established_flag) else $error("homing granted");
  a_abs_needs_req: assert property (
    abs_move_grant |-> abs_move_req) else $error("abs move granted unasked");
  a_abs_with_coord: assert property (
    abs_move_req && coordinate_established_flag |-> abs_move_grant) else $error("abs refused");
  a_factory_follows: assert property (
    !$past(rst) |-> factory_home_stored_flag == $past(factory_home)) else $error("factory flag");
  a_user_store: assert property (
    $rose(user_home_stored_flag) |-> nvm_write || $past(nvm_write)) else $error("no store");
  a_store_pulse: assert property (
    nvm_write |=> !nvm_write) else $error("store pulse too long");
  a_store_sets_user: assert property (
    nvm_write |-> ##[0:1] user_home_stored_flag) else $error("user flag missing");
  a_reset_clears: assert property (
    $past(rst) |-> !coordinate_established_flag && !user_home_stored_flag && !nvm_write)
    else $error("flags after reset");
  c_store: cover property (nvm_write);
  c_abs: cover property (abs_move_grant);
  c_refuse: cover property (homing_req && !homing_grant);
endmodule // mtpc_core_asserts
bind mtpc_core mtpc_core_asserts chk (.clk(clk), .rst(rst), .homing_req(homing_req),
  .abs_move_req(abs_move_req), .homing_grant(homing_grant), .abs_move_grant(abs_move_grant),
  .factory_home(factory_home), .coordinate_established_flag(coordinate_established_flag),
  .factory_home_stored_flag(factory_home_stored_flag),
  .user_home_stored_flag(user_home_stored_flag), .nvm_write(nvm_write));
`default_nettype wire

/* verif/multi_turn_position_coordinate_tb.sv */
`default_nettype none
module multi_turn_position_coordinate_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SR = 4;  // Short revolution so a wrap is reached in a few hundred steps.
  typedef struct {logic [31:0] d; logic [31:0] m;} note_t;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, pv;
  logic        pready, pslverr, step_pulse, step_dir, busy, go = 1'b0, dir = 1'b1;
  logic        slow = 1'b0, factory_home = 1'b0, homing_req = 1'b0, abs_move_req = 1'b0;
  logic        homing_grant, abs_move_grant, coord, fac, usr, nvm_write;
  logic [15:0] cnt = 16'h0, k;
  int          bad_count = 0, check_count = 0;
  note_t       q[$];
  always #2 clk = ~clk;
  shaft_sensor_model sensor (.clk(clk), .go(go), .count(cnt), .dir(dir), .slow(slow),
    .step_pulse(step_pulse), .step_dir(step_dir), .busy(busy));
  mtpc_core #(.STEPS_REV(SR)) dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .small_frame(1'b0), .step_pulse(step_pulse), .step_dir(step_dir),
    .factory_home(factory_home), .homing_req(homing_req), .abs_move_req(abs_move_req),
    .homing_grant(homing_grant), .abs_move_grant(abs_move_grant),
    .coordinate_established_flag(coord), .factory_home_stored_flag(fac),
    .user_home_stored_flag(usr), .nvm_write(nvm_write));
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{e & m, m});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic power(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic spin(input logic d, input logic [15:0] n, input logic s);
    int t;
    t = 0;
    go <= 1'b1;
    dir <= d;
    cnt <= n;
    slow <= s;
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (busy && ++t < 5000);
    repeat (2) @(posedge clk);
  endtask
  // Read data is judged at the access edge, in the order the reads were issued.
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0) begin
      chk(prdata & q[0].m, q[0].d);
      void'(q.pop_front());
    end
  end
  initial begin
    #80000;
    bad_count++;
    summarize();
  end
  initial begin
    void'($urandom(4598));
    power(8);
    rd(mtpc_pkg::OFF_LOWER, 32'hfffffc7c, 32'hffffffff);
    rd(mtpc_pkg::OFF_UPPER, 32'h00000384, 32'hffffffff);
    rd(mtpc_pkg::OFF_STATUS, 32'h0, 32'h7);
    rd(8'h34, 32'h0, 32'hffffffff);
    homing_req <= 1'b1;
    abs_move_req <= 1'b1;
    @(negedge clk);
    chk({30'h0, homing_grant, abs_move_grant}, 32'h0);
    @(posedge clk);
    homing_req <= 1'b0;
    pv = $urandom;
    apb(1'b1, mtpc_pkg::OFF_PRESET, pv);
    apb(1'b1, mtpc_pkg::OFF_CMD, 32'h1);
    rd(mtpc_pkg::OFF_STATUS, 32'h5, 32'h5);
    rd(mtpc_pkg::OFF_POSITION, pv, 32'hffffffff);
    @(negedge clk);
    chk({31'h0, abs_move_grant}, 32'h1);
    @(posedge clk);
    abs_move_req <= 1'b0;
    factory_home <= 1'b1;
    k = 16'($urandom_range(1, 40));
    spin(1'b1, k, 1'b0);
    rd(mtpc_pkg::OFF_POSITION, pv + 32'(k), 32'hffffffff);
    apb(1'b1, mtpc_pkg::OFF_CMD, 32'h2);
    rd(mtpc_pkg::OFF_STATUS, 32'h2, 32'h6);
    // A range of 100 revolutions divides the span evenly, so wraps stay aligned.
    apb(1'b1, mtpc_pkg::OFF_RANGE, 32'd100);
    apb(1'b1, mtpc_pkg::OFF_RATIO, 32'd500);
    apb(1'b1, mtpc_pkg::OFF_CTRL, 32'h5);
    rd(mtpc_pkg::OFF_LOWER, 32'hfffffc7c, 32'hffffffff);
    power(2);
    rd(mtpc_pkg::OFF_LOWER, 32'hfffffffb, 32'hffffffff);
    rd(mtpc_pkg::OFF_UPPER, 32'd95, 32'hffffffff);
    apb(1'b1, mtpc_pkg::OFF_PRESET, 32'h0);
    apb(1'b1, mtpc_pkg::OFF_CMD, 32'h1);
    spin(1'b1, 16'(95 * SR + 2), 1'b1);
    rd(mtpc_pkg::OFF_POSITION, 32'hffffffee, 32'hffffffff);
    rd(mtpc_pkg::OFF_STEPS, 32'(95 * SR + 2), 32'hffffffff);
    spin(1'b0, 16'(95 * SR + 2), 1'b0);
    rd(mtpc_pkg::OFF_POSITION, 32'h0, 32'hffffffff);
    rd(mtpc_pkg::OFF_STEPS, 32'h0, 32'hffffffff);
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule // multi_turn_position_coordinate_tb
`default_nettype wire
